/* File: expander_pkg.sv */
// Shared constants, layouts and helper functions of the peripheral interrupt expander.
// Assumes a 32-bit classic Wishbone bus whose word index is the byte address divided by four.
package expander_pkg;

	localparam int WORD_W = 16;
	localparam int SRC_N = 32;
	localparam int LEVEL_N = 6;

	// Register word indices; byte address is four times the index
	localparam logic [15:0] REQ_LOW_IDX = 16'h7010;
	localparam logic [15:0] REQ_HIGH_IDX = 16'h7011;
	localparam logic [15:0] ACK_LOW_IDX = 16'h7014;
	localparam logic [15:0] ACK_HIGH_IDX = 16'h7015;
	localparam logic [15:0] VECTOR_IDX = 16'h701e;
	localparam logic [15:0] MASK_IDX = 16'h7004;

	// Field layouts and reset values
	localparam logic [15:0] HIGH_VALID = 16'h7fff;
	localparam logic [31:0] SRC_VALID = 32'h7fff_ffff;
	localparam logic [15:0] REQ_RESET = 16'h0000;
	localparam logic [15:0] VECTOR_RESET = 16'h0000;
	localparam logic [15:0] VECTOR_BASE = 16'h0020;
	localparam logic [15:0] PHANTOM_VECTOR = 16'h0011;
	localparam logic [LEVEL_N-1:0] FLAGS_RESET = 6'h00;

	// Sources feeding each CPU level
	localparam logic [31:0] LEVEL_ONE_SRC = 32'h0000_01ff;
	localparam logic [31:0] LEVEL_TWO_SRC = 32'h0000_fe00;
	localparam logic [31:0] LEVEL_THREE_SRC = 32'h000f_0000;
	localparam logic [31:0] LEVEL_FOUR_SRC = 32'h0070_0000;
	localparam logic [31:0] LEVEL_FIVE_SRC = 32'h0f80_0000;
	localparam logic [31:0] LEVEL_SIX_SRC = 32'h7000_0000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01,
		BUS_REST = 2'b11
	} bus_state_e;

	function automatic logic [31:0] level_sources(input logic [2:0] lvl);
		case (lvl)
			3'h1: level_sources = LEVEL_ONE_SRC;
			3'h2: level_sources = LEVEL_TWO_SRC;
			3'h3: level_sources = LEVEL_THREE_SRC;
			3'h4: level_sources = LEVEL_FOUR_SRC;
			3'h5: level_sources = LEVEL_FIVE_SRC;
			3'h6: level_sources = LEVEL_SIX_SRC;
			default: level_sources = 32'h0000_0000;
		endcase
	endfunction : level_sources

	function automatic logic [15:0] vector_of(input logic [4:0] idx);
		vector_of = VECTOR_BASE + {11'h000, idx};
	endfunction : vector_of

	function automatic logic [15:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

endpackage : expander_pkg

/* File: bus_port.sv */
// Classic Wishbone slave handshake: one ack per request, then one idle cycle.
// Assumes the master holds its request until it samples ack and then drops stb for a cycle.
`timescale 1ns/1ns
module bus_port (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	output logic take_o,
	output logic ack_o,
	output logic write_o
);
	import expander_pkg::*;

	bus_state_e state;
	bus_state_e next_state;

	assign take_o = (state == BUS_IDLE) && cyc_i && stb_i;
	assign ack_o = (state == BUS_ANSWER);
	// Writes land on the ack edge, the only edge the master commits on
	assign write_o = ack_o && we_i;

	always_comb begin
		case (state)
			BUS_IDLE: next_state = take_o ? BUS_ANSWER : BUS_IDLE;
			BUS_ANSWER: next_state = BUS_REST;
			BUS_REST: next_state = BUS_IDLE;
			default: next_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= BUS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	bus_single_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

endmodule : bus_port

/* File: level_picker.sv */
// Picks the highest-priority pending source of one CPU level; lower bit index wins.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ns
module level_picker (
	input wire logic [31:0] pending_i,
	input wire logic [2:0] level_i,
	output logic found_o,
	output logic [4:0] index_o
);
	import expander_pkg::*;

	logic [31:0] candidates;

	assign candidates = pending_i & level_sources(level_i);
	assign found_o = |candidates;

	always_comb begin
		index_o = 5'h00;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (candidates[i]) begin
				index_o = 5'(i);
			end
		end
	end

endmodule : level_picker

/* File: peripheral_expander.sv */
// Peripheral interrupt expander: 31 peripheral requests grouped onto six masked CPU levels.
// Assumes a classic Wishbone master, single-cycle peripheral event pulses and a CPU acknowledge pulse.
`timescale 1ns/1ns
module peripheral_expander (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [31:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic ACK_O,
	input wire logic [31:0] PERIPH_REQ_I,
	output logic [31:0] PERIPH_ACK_O,
	input wire logic GLOBAL_MODE_I,
	input wire logic CPU_IACK_I,
	input wire logic [2:0] CPU_IACK_LEVEL_I,
	output logic [expander_pkg::LEVEL_N-1:0] LEVEL_REQ_O,
	output logic [expander_pkg::LEVEL_N-1:0] LEVEL_TAKE_O
);
	import expander_pkg::*;

	logic bus_take;
	logic bus_write;
	logic [15:0] word_idx;
	logic addr_upper_zero;
	logic hit_req_low;
	logic hit_req_high;
	logic hit_ack_low;
	logic hit_ack_high;
	logic hit_vector;
	logic hit_mask;
	logic [15:0] wr_lanes;
	logic [15:0] wr_ones;
	logic [31:0] sw_set;
	logic [31:0] sw_clr;
	logic [31:0] hw_clr;
	logic [31:0] periph_set;
	logic [31:0] request;
	logic [31:0] next_request;
	logic [31:0] next_periph_ack;
	logic [15:0] vector;
	logic [15:0] core_level_mask;
	logic [LEVEL_N-1:0] core_level_flags;
	logic [LEVEL_N-1:0] next_flags;
	logic [LEVEL_N-1:0] level_pending;
	logic [LEVEL_N-1:0] hw_level_clr;
	logic [15:0] rd_word;
	logic iack_level_valid;
	logic cpu_ack_ok;
	logic pick_found;
	logic [4:0] pick_index;
	logic seen_ack;

	bus_port u_bus_port (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.cyc_i(CYC_I),
		.stb_i(STB_I),
		.we_i(WE_I),
		.take_o(bus_take),
		.ack_o(ACK_O),
		.write_o(bus_write)
	);

	level_picker u_level_picker (
		.pending_i(request),
		.level_i(CPU_IACK_LEVEL_I),
		.found_o(pick_found),
		.index_o(pick_index)
	);

	// Address decode; an unmapped address still gets an ack with zero data
	assign word_idx = ADR_I[17:2];
	assign addr_upper_zero = (ADR_I[31:18] == 14'h0000);
	assign hit_req_low = addr_upper_zero && (word_idx == REQ_LOW_IDX);
	assign hit_req_high = addr_upper_zero && (word_idx == REQ_HIGH_IDX);
	assign hit_ack_low = addr_upper_zero && (word_idx == ACK_LOW_IDX);
	assign hit_ack_high = addr_upper_zero && (word_idx == ACK_HIGH_IDX);
	assign hit_vector = addr_upper_zero && (word_idx == VECTOR_IDX);
	assign hit_mask = addr_upper_zero && (word_idx == MASK_IDX);

	assign wr_lanes = lane_mask(SEL_I);
	assign wr_ones = DAT_I[15:0] & wr_lanes;

	// Two 16-bit groups make one 32-bit request vector of 31 sources; bit 31 is reserved
	assign sw_set = {(bus_write && hit_req_high) ? (wr_ones & HIGH_VALID) : 16'h0000,
		(bus_write && hit_req_low) ? wr_ones : 16'h0000};
	assign sw_clr = {(bus_write && hit_ack_high) ? (wr_ones & HIGH_VALID) : 16'h0000,
		(bus_write && hit_ack_low) ? wr_ones : 16'h0000};
	assign periph_set = PERIPH_REQ_I & SRC_VALID;

	// CPU acknowledge is honoured only for a level that is currently taken
	assign iack_level_valid = (CPU_IACK_LEVEL_I >= 3'h1) && (CPU_IACK_LEVEL_I <= 3'h6);
	assign cpu_ack_ok = CPU_IACK_I && iack_level_valid && LEVEL_TAKE_O[CPU_IACK_LEVEL_I - 3'h1];
	assign hw_clr = (cpu_ack_ok && pick_found) ? (32'h0000_0001 << pick_index) : 32'h0000_0000;
	assign hw_level_clr = cpu_ack_ok ? (6'h01 << (CPU_IACK_LEVEL_I - 3'h1)) : 6'h00;

	// A new event in the clearing cycle survives: set beats clear
	assign next_request = ((request & ~(sw_clr | hw_clr)) | sw_set | periph_set) & SRC_VALID;
	assign next_periph_ack = sw_clr | hw_clr;

	always_comb begin
		for (int l = 0; l < LEVEL_N; l++) begin
			level_pending[l] = |(request & level_sources(3'(l + 1)));
		end
	end

	// Acknowledge beats the pending view of the same cycle; the flag re-arms next edge if sources remain
	assign next_flags = (core_level_flags | level_pending) & ~hw_level_clr;
	assign LEVEL_REQ_O = level_pending;
	assign LEVEL_TAKE_O = core_level_flags & core_level_mask[LEVEL_N-1:0] & {LEVEL_N{!GLOBAL_MODE_I}};

	// Read mux; acknowledge registers have no storage and read as zero
	assign rd_word = hit_req_low ? request[15:0] :
		hit_req_high ? (request[31:16] & HIGH_VALID) :
		hit_vector ? vector :
		hit_mask ? core_level_mask :
		16'h0000;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DAT_O <= 32'h0000_0000;
		end else if (bus_take) begin
			DAT_O <= {16'h0000, rd_word};
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			request <= {REQ_RESET, REQ_RESET};
			core_level_flags <= FLAGS_RESET;
			PERIPH_ACK_O <= 32'h0000_0000;
		end else begin
			request <= next_request;
			core_level_flags <= next_flags;
			PERIPH_ACK_O <= next_periph_ack;
		end
	end

	// Only the hardware acknowledge path writes the vector
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			vector <= VECTOR_RESET;
		end else if (cpu_ack_ok) begin
			vector <= pick_found ? vector_of(pick_index) : PHANTOM_VECTOR;
		end
	end

	// Deliberately no reset: the mask survives a device reset and powers up undefined
	always_ff @(posedge CLK_I) begin
		if (bus_write && hit_mask) begin
			core_level_mask <= (core_level_mask & ~wr_lanes) | (DAT_I[15:0] & wr_lanes);
		end
	end

	// Checker-only history of whether any hardware acknowledge has happened
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			seen_ack <= 1'b0;
		end else if (cpu_ack_ok) begin
			seen_ack <= 1'b1;
		end
	end

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence ack_with_source;
		cpu_ack_ok && pick_found;
	endsequence

	sequence ack_without_source;
		cpu_ack_ok && !pick_found;
	endsequence

	vector_load_a: assert property (ack_with_source |=> vector == vector_of($past(pick_index)))
		else $error("vector not loaded from top pending source");

	vector_phantom_a: assert property (ack_without_source |=> vector == PHANTOM_VECTOR)
		else $error("phantom vector not loaded");

	vector_hold_a: assert property (!cpu_ack_ok |=> $stable(vector))
		else $error("vector changed without hardware acknowledge");

	soft_ack_vector_a: assert property ((bus_write && (hit_ack_low || hit_ack_high)) && !cpu_ack_ok
		|=> $stable(vector))
		else $error("acknowledge register write changed vector");

	vector_reset_a: assert property (!seen_ack |-> vector == VECTOR_RESET)
		else $error("vector not zero before first acknowledge");

	reserved_bit_a: assert property (!request[31] && !PERIPH_ACK_O[31])
		else $error("reserved high-group bit became set");

	request_read_a: assert property (bus_take && hit_req_low && !WE_I
		|=> ACK_O && DAT_O[15:0] == $past(request[15:0]))
		else $error("request register read mismatch");

	ack_read_zero_a: assert property (bus_take && (hit_ack_low || hit_ack_high) && !WE_I
		|=> ACK_O && DAT_O == 32'h0000_0000)
		else $error("acknowledge register read not zero");

	soft_set_a: assert property (bus_write && hit_req_low
		|=> (request[15:0] & $past(sw_set[15:0])) == $past(sw_set[15:0]))
		else $error("request write did not raise requests");

	soft_ack_high_a: assert property (bus_write && hit_ack_high && !cpu_ack_ok
		&& (periph_set[30:16] & sw_clr[30:16]) == 15'h0000
		|=> (request[30:16] & $past(sw_clr[30:16])) == 15'h0000 && PERIPH_ACK_O[30:16] == $past(sw_clr[30:16]))
		else $error("high-group acknowledge did not clear and pulse");

	masked_level_a: assert property ((LEVEL_TAKE_O & ~core_level_mask[LEVEL_N-1:0]) == 6'h00
		&& (!GLOBAL_MODE_I || LEVEL_TAKE_O == 6'h00))
		else $error("masked or globally disabled level taken");

	level_map_a: assert property (LEVEL_REQ_O[1] == |request[15:9] && LEVEL_REQ_O[4] == |request[27:23])
		else $error("level grouping mismatch");

	hw_single_clear_a: assert property ((ack_with_source
		and ((periph_set | sw_set) & hw_clr) == 32'h0000_0000)
		|=> !request[$past(pick_index)] && PERIPH_ACK_O == $past(next_periph_ack))
		else $error("hardware acknowledge did not clear its source");

	sequence read_taken;
		bus_take && !WE_I;
	endsequence

	sequence hw_ack_taken;
		cpu_ack_ok && !bus_write;
	endsequence

	take_then_ack_a: assert property (bus_take
		|=> ACK_O)
		else $error("no ack after taken request");

	data_hold_a: assert property (!bus_take
		|=> $stable(DAT_O))
		else $error("read data changed without request");

	addr_miss_zero_a: assert property ((read_taken and !(hit_req_low || hit_req_high || hit_vector || hit_mask))
		|=> DAT_O == 32'h0000_0000)
		else $error("unmapped read not zero");

	vector_read_a: assert property ((read_taken and hit_vector)
		|=> ACK_O && DAT_O[15:0] == $past(vector))
		else $error("vector read mismatch");

	vector_write_ignored_a: assert property (bus_write && hit_vector && !cpu_ack_ok
		|=> $stable(vector))
		else $error("vector write took effect");

	req_high_read_a: assert property ((read_taken and hit_req_high)
		|=> DAT_O[15:0] == {1'b0, $past(request[30:16])})
		else $error("high request read mismatch");

	soft_set_high_a: assert property (bus_write && hit_req_high
		|=> (request[30:16] & $past(wr_ones[14:0])) == $past(wr_ones[14:0]))
		else $error("high request write did not raise requests");

	soft_ack_low_a: assert property (bus_write && hit_ack_low && !cpu_ack_ok
		&& (periph_set[15:0] & wr_ones) == 16'h0000
		|=> (request[15:0] & $past(wr_ones)) == 16'h0000 && PERIPH_ACK_O[15:0] == $past(wr_ones))
		else $error("low acknowledge did not clear and pulse");

	req_write_keeps_a: assert property (bus_write && hit_req_low && !cpu_ack_ok
		|=> ($past(request[15:0]) & ~request[15:0]) == 16'h0000)
		else $error("request write cleared a request");

	periph_capture_a: assert property (periph_set != 32'h0000_0000
		|=> (request & $past(periph_set)) == $past(periph_set))
		else $error("peripheral event not captured");

	level_one_map_a: assert property (LEVEL_REQ_O[0] == |request[8:0])
		else $error("level one grouping mismatch");

	level_three_four_a: assert property (LEVEL_REQ_O[2] == |request[19:16]
		&& LEVEL_REQ_O[3] == |request[22:20])
		else $error("level three or four grouping mismatch");

	level_six_map_a: assert property (LEVEL_REQ_O[5] == |request[30:28])
		else $error("level six grouping mismatch");

	take_needs_flag_a: assert property ((LEVEL_TAKE_O & ~core_level_flags) == 6'h00)
		else $error("level taken without its flag");

	unmasked_take_a: assert property ((core_level_flags & core_level_mask[LEVEL_N-1:0]) != 6'h00
		&& !GLOBAL_MODE_I |-> LEVEL_TAKE_O != 6'h00)
		else $error("flagged unmasked level not taken");

	mask_write_a: assert property (bus_write && hit_mask && SEL_I[1:0] == 2'b11
		|=> core_level_mask == $past(DAT_I[15:0]))
		else $error("mask write did not land");

	flag_set_a: assert property (level_pending != 6'h00 && !cpu_ack_ok
		|=> (core_level_flags & $past(level_pending)) == $past(level_pending))
		else $error("pending level did not flag");

	flag_clear_a: assert property (cpu_ack_ok
		|=> !core_level_flags[$past(CPU_IACK_LEVEL_I) - 3'h1])
		else $error("acknowledged level flag not cleared");

	hw_ack_one_bit_a: assert property (hw_ack_taken
		|=> $onehot0(PERIPH_ACK_O))
		else $error("hardware acknowledge pulsed several sources");

	hw_ack_level_a: assert property (ack_with_source
		|-> (hw_clr & ~level_sources(CPU_IACK_LEVEL_I)) == 32'h0000_0000)
		else $error("hardware acknowledge outside its level");

	hw_ack_top_a: assert property (ack_with_source
		|-> ((hw_clr - 32'h0000_0001) & request & level_sources(CPU_IACK_LEVEL_I)) == 32'h0000_0000)
		else $error("hardware acknowledge skipped a higher priority source");

	hw_ack_pulse_a: assert property (ack_with_source
		|=> PERIPH_ACK_O[$past(pick_index)])
		else $error("hardware acknowledge not pulsed to source");

	ack_write_no_set_a: assert property (bus_write && (hit_ack_low || hit_ack_high)
		&& periph_set == 32'h0000_0000 |=> (request & ~$past(request)) == 32'h0000_0000)
		else $error("acknowledge write raised a request");

	periph_ack_idle_a: assert property (!bus_write && !cpu_ack_ok
		|=> PERIPH_ACK_O == 32'h0000_0000)
		else $error("source acknowledge without cause");

endmodule : peripheral_expander

/* File: cpu_core_model.sv */
// Behavioural CPU core: acknowledges one commanded level once the expander lets it be taken.
// Assumes the bench pulses go_i for one cycle with level_i valid beside it.
`timescale 1ns/1ns
module cpu_core_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] take_i,
	input wire logic go_i,
	input wire logic [2:0] level_i,
	output logic iack_o,
	output logic [2:0] iack_level_o,
	output logic done_o
);
	logic waiting;
	// Waits on the take output, so a slow or blocked level simply leaves the core idle
	wire logic can_take = waiting && take_i[iack_level_o - 3'h1];
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			waiting <= 1'b0;
			iack_o <= 1'b0;
			iack_level_o <= 3'h0;
			done_o <= 1'b0;
		end else begin
			iack_o <= can_take;
			done_o <= can_take;
			if (go_i) begin
				waiting <= 1'b1;
				iack_level_o <= level_i;
			end else if (can_take) begin
				waiting <= 1'b0;
			end
		end
	end
endmodule : cpu_core_model

/* File: peripheral_expander_bench.sv */
// Self-checking bench for the peripheral interrupt expander.
// Assumes the core model above answers hardware acknowledges; the bench is the Wishbone master.
`timescale 1ns/1ns
module peripheral_expander_bench;
	import expander_pkg::*;
	logic clk, rst_n, cyc, stb, we, gmode, go, ack, iack, done, clr;
	logic [31:0] adr, wdat, rdat, preq, pack, seen;
	logic [3:0] sel;
	logic [2:0] lvl, ilvl;
	logic [5:0] lreq, ltake;
	logic [15:0] rd;
	int errors, cmp_count;

	peripheral_expander u_dut (.CLK_I(clk), .RST_N_I(rst_n), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat), .WE_I(we),
		.SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .PERIPH_REQ_I(preq), .PERIPH_ACK_O(pack),
		.GLOBAL_MODE_I(gmode), .CPU_IACK_I(iack), .CPU_IACK_LEVEL_I(ilvl), .LEVEL_REQ_O(lreq), .LEVEL_TAKE_O(ltake));
	cpu_core_model u_cpu (.clk_i(clk), .rst_n_i(rst_n), .take_i(ltake), .go_i(go), .level_i(lvl),
		.iack_o(iack), .iack_level_o(ilvl), .done_o(done));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Sticky record of acknowledge pulses, since each lasts a single cycle
	always @(posedge clk) seen <= clr ? 32'h0 : (seen | pack);

	task automatic report_and_stop;
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] wd, output logic [15:0] rv);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {14'h0, idx, 2'b00};
		wdat <= {16'h0, wd};
		sel <= 4'h3;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			report_and_stop();
		end
		rv = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
		bus(1'b1, idx, wd, rd);
	endtask : wr

	task automatic rdc(input logic [15:0] idx, input logic [15:0] exp, input string what);
		bus(1'b0, idx, 16'h0, rd);
		check(what, 32'(rd), 32'(exp));
	endtask : rdc

	task automatic pulse(input logic [31:0] v);
		@(posedge clk) preq <= v;
		@(posedge clk) preq <= 32'h0;
	endtask : pulse

	task automatic cpu_ack(input logic [2:0] l);
		int n;
		n = 0;
		@(posedge clk);
		go <= 1'b1;
		lvl <= l;
		@(posedge clk) go <= 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			errors++;
			report_and_stop();
		end
		@(posedge clk);
	endtask : cpu_ack

	function automatic logic [5:0] level_of(input int i);
		if (i < 9) return 6'h01;
		if (i < 16) return 6'h02;
		if (i < 20) return 6'h04;
		if (i < 23) return 6'h08;
		if (i < 28) return 6'h10;
		return 6'h20;
	endfunction : level_of

	task automatic t_reset;
		wr(MASK_IDX, 16'h0015);
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(MASK_IDX, 16'h0015, "mask kept");
		rdc(REQ_LOW_IDX, REQ_RESET, "req low reset");
		rdc(REQ_HIGH_IDX, REQ_RESET, "req high reset");
		rdc(VECTOR_IDX, VECTOR_RESET, "vector reset");
		wr(VECTOR_IDX, 16'hffff);
		rdc(VECTOR_IDX, VECTOR_RESET, "vector read only");
		rdc(16'h7020, 16'h0000, "unmapped");
	endtask : t_reset

	task automatic t_req_bits;
		wr(REQ_HIGH_IDX, 16'hffff);
		rdc(REQ_HIGH_IDX, HIGH_VALID, "req high set");
		wr(ACK_HIGH_IDX, 16'hffff);
		rdc(REQ_HIGH_IDX, 16'h0000, "req high cleared");
		rdc(ACK_HIGH_IDX, 16'h0000, "ack high read");
		wr(REQ_LOW_IDX, 16'h0001);
		wr(REQ_LOW_IDX, 16'h0000);
		rdc(REQ_LOW_IDX, 16'h0001, "req zero write");
		rdc(ACK_LOW_IDX, 16'h0000, "ack low read");
		wr(ACK_LOW_IDX, 16'h0001);
		rdc(REQ_LOW_IDX, 16'h0000, "req low cleared");
	endtask : t_req_bits

	// Every source in turn, bit 31 included to show it is ignored
	task automatic t_sources;
		for (int i = 0; i < 32; i++) begin
			@(posedge clk) clr <= 1'b1;
			preq <= 32'h1 << i;
			@(posedge clk) clr <= 1'b0;
			preq <= 32'h0;
			@(posedge clk);
			check("level map", 32'(lreq), i < 31 ? 32'(level_of(i)) : 32'h0);
			rdc(i < 16 ? REQ_LOW_IDX : REQ_HIGH_IDX, i < 31 ? 16'h1 << (i % 16) : 16'h0, "req bit");
			wr(i < 16 ? ACK_LOW_IDX : ACK_HIGH_IDX, 16'h1 << (i % 16));
			repeat (2) @(posedge clk);
			check("level cleared", 32'(lreq), 32'h0);
			check("source ack", seen, i < 31 ? 32'h1 << i : 32'h0);
		end
	endtask : t_sources

	task automatic t_cpu_ack;
		wr(MASK_IDX, 16'h003f);
		pulse(32'h0000_0028);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		cpu_ack(3'h1);
		rdc(VECTOR_IDX, VECTOR_BASE + 16'h0003, "top vector");
		check("hw source ack", seen, 32'h0000_0008);
		rdc(REQ_LOW_IDX, 16'h0020, "only top cleared");
		check("level still raised", 32'(lreq), 32'h1);
		wr(ACK_LOW_IDX, 16'h0020);
		rdc(VECTOR_IDX, VECTOR_BASE + 16'h0003, "vector kept");
		cpu_ack(3'h1);
		rdc(VECTOR_IDX, PHANTOM_VECTOR, "phantom");
		pulse(32'h0280_0000);
		cpu_ack(3'h5);
		rdc(VECTOR_IDX, VECTOR_BASE + 16'h0017, "high vector");
		rdc(REQ_HIGH_IDX, 16'h0200, "next pending");
	endtask : t_cpu_ack

	task automatic t_take_gate;
		pulse(32'h0001_0000);
		wr(MASK_IDX, 16'h003b);
		@(posedge clk);
		check("masked take", 32'(ltake[2]), 32'h0);
		check("masked request", 32'(lreq[2]), 32'h1);
		wr(MASK_IDX, 16'h003f);
		@(posedge clk);
		check("unmasked take", 32'(ltake[2]), 32'h1);
		@(posedge clk) gmode <= 1'b1;
		@(posedge clk);
		check("global mode", 32'(ltake), 32'h0);
		@(posedge clk) gmode <= 1'b0;
		cpu_ack(3'h3);
		rdc(VECTOR_IDX, VECTOR_BASE + 16'h0010, "level three vector");
		check("level three released", 32'(ltake[2]), 32'h0);
	endtask : t_take_gate

	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		{cyc, stb, we, gmode, go, clr} = 6'h00;
		{adr, wdat, preq} = {32'h0, 32'h0, 32'h0};
		sel = 4'h0;
		lvl = 3'h0;
		errors = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_req_bits();
		t_sources();
		t_cpu_ack();
		t_take_gate();
		report_and_stop();
	end
endmodule : peripheral_expander_bench
